// File: inc/dsta_pkg.sv
// shared constants and state types for the stream dma aligner
package dsta_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_PAY_ADDR  = 8'h00;
  localparam logic [7:0] OFS_PAY_LEN   = 8'h04;
  localparam logic [7:0] OFS_FOOT_ADDR = 8'h08;
  localparam logic [7:0] OFS_STATUS    = 8'h0c;
  // reset values of the writable address registers
  localparam logic [31:0] RST_PAY_ADDR  = 32'h0000_0000;
  localparam logic [31:0] RST_FOOT_ADDR = 32'h0000_0000;
  // burst and line geometry, in words, footer length in bytes
  localparam logic [4:0] BURST_LAST = 5'h1f;
  localparam logic [4:0] LINE_LAST  = 5'h07;
  localparam logic [3:0] HDR_WORDS  = 4'h8;
  localparam logic [4:0] FOOT_KEEP  = 5'h03;
  localparam logic [7:0] FOOT_BYTES = 8'h20;
  // byte masks, one bit suppresses a lane
  localparam logic [3:0] MASK_PAD   = 4'hf;
  // transmit framing sequencer
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_SOF = 3'b001, TX_HDR = 3'b010,
    TX_PBEG = 3'b011, TX_PAY = 3'b100, TX_PFIN = 3'b101,
    TX_FFIN = 3'b110
  } dsta_tx_t;
  // receive stream phase
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_HDR = 3'b001, RX_WAIT = 3'b010,
    RX_BURST = 3'b011, RX_FOOT = 3'b100
  } dsta_rx_t;
  // receive word load sequencer
  typedef enum logic [1:0] {
    SH_IDLE = 2'b00, SH_EVEN = 2'b01, SH_ODD = 2'b10
  } dsta_sh_t;
endpackage

// File: logic/dsta_top.sv
// stream dma channel: transmit framing and receive byte aligner
`timescale 1ns/10ps
module dsta_top #(
  parameter int AW    = 32,
  parameter int LEN_W = 16
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // port sequencer orders
  input  wire logic             tx_frame_start,
  input  wire logic             read_desc_done,
  input  wire logic             tx_more_words,
  input  wire logic             last_word_trigger,
  input  wire logic             rx_frame_start,
  input  wire logic             burst32_write_request,
  input  wire logic             line8_write_request,
  // transmit word source
  input  wire logic [31:0]      tx_word,
  input  wire logic             tx_word_valid,
  // transmit stream
  output logic      [31:0]      tx_data,
  output logic                  tx_src_rdy,
  input  wire logic             tx_dst_rdy,
  output logic                  tx_sof,
  output logic                  payload_start_marker,
  output logic                  payload_end_marker,
  output logic                  tx_eof,
  // receive stream
  input  wire logic [31:0]      rx_data,
  input  wire logic             rx_src_rdy,
  input  wire logic             rx_sop,
  output logic                  rx_dst_rdy,
  // memory write port
  output logic      [31:0]      write_word_even,
  output logic      [31:0]      write_word_odd,
  output logic      [3:0]       write_mask_even,
  output logic      [3:0]       write_mask_odd,
  output logic                  write_accept_even,
  output logic                  write_accept_odd
);
  // refuse widths the counters cannot serve
  if (AW < 8 || AW > 32 || LEN_W < 8 || LEN_W > 32) begin : g_bad
    $error("dsta_top: unsupported AW or LEN_W");
  end

  // mask of lanes outside [f, f+k), first byte is bit 3
  function automatic logic [3:0] lane_mask(input logic [1:0] f,
                                           input logic [2:0] k);
    logic [3:0] m;
    m = dsta_pkg::MASK_PAD;
    for (int j = 0; j < 4; j++) begin
      if (4'(j) >= {2'b00, f} && 4'(j) < 4'({2'b00, f}) + 4'(k)) begin
        m[3-j] = 1'b0;
      end
    end
    return m;
  endfunction

  // software registers
  logic [AW-1:0]    pay_addr_q;   // payload buffer byte address
  logic [LEN_W-1:0] pay_len_q;    // payload length in bytes
  logic [AW-1:0]    foot_addr_q;  // descriptor address for footer
  // state
  dsta_pkg::dsta_tx_t tx_st_q, tx_st_d;
  dsta_pkg::dsta_rx_t rx_st_q, rx_st_d;
  dsta_pkg::dsta_sh_t sh_q, sh_d;
  logic [3:0]       hdr_cnt_q, hdr_cnt_d; // header words forwarded
  logic [AW-1:0]    cur_q, cur_d; // next byte address to write
  logic [LEN_W-1:0] outl_q, outl_d; // bytes still to write
  logic [LEN_W-1:0] inl_q, inl_d; // bytes still to pull
  logic [63:0]      buf_q, buf_d; // aligner window, first byte on top
  logic [3:0]       nb_q, nb_d;   // bytes held in window
  logic [4:0]       slot_q;       // word slot within burst
  logic [AW-3:0]    base_q;       // word address of burst start
  logic             foot_q;       // footer pass in progress
  // aligner terms
  logic [AW-3:0]    wa;           // word address of current slot
  logic             pad;          // slot lies outside the data
  logic [1:0]       f;            // first valid lane
  logic [2:0]       room, k, pb, cons;
  logic             push, active, emit, last_slot;
  logic [63:0]      win;
  logic [3:0]       have, mask;
  logic [31:0]      word_out;
  logic [2:0]       shift_off;    // byte rotation of the payload
  logic             load_even, load_odd;

  // apb access: one wait-free answer in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      unique case (paddr)
        dsta_pkg::OFS_PAY_ADDR:  prdata <= 32'(pay_addr_q);
        dsta_pkg::OFS_PAY_LEN:   prdata <= 32'(pay_len_q);
        dsta_pkg::OFS_FOOT_ADDR: prdata <= 32'(foot_addr_q);
        dsta_pkg::OFS_STATUS: begin
          prdata <= {19'h0, (outl_q != '0), nb_q, sh_q,
                     rx_st_q, tx_st_q};
        end
        default: pslverr <= 1'b1;
      endcase
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // apb register writes, taken at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pay_addr_q  <= AW'(dsta_pkg::RST_PAY_ADDR);
      pay_len_q   <= '0;
      foot_addr_q <= AW'(dsta_pkg::RST_FOOT_ADDR);
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == dsta_pkg::OFS_PAY_ADDR) begin
        pay_addr_q <= AW'(pwdata);
      end
      if (paddr == dsta_pkg::OFS_PAY_LEN) begin
        pay_len_q <= LEN_W'(pwdata);
      end
      if (paddr == dsta_pkg::OFS_FOOT_ADDR) begin
        foot_addr_q <= AW'(pwdata);
      end
    end
  end

  // transmit sequencer next state
  always_comb begin
    tx_st_d = tx_st_q;
    unique case (tx_st_q)
      dsta_pkg::TX_IDLE: if (tx_frame_start) tx_st_d = dsta_pkg::TX_SOF;
      dsta_pkg::TX_SOF:  if (tx_dst_rdy) tx_st_d = dsta_pkg::TX_HDR;
      dsta_pkg::TX_HDR:  if (read_desc_done) tx_st_d = dsta_pkg::TX_PBEG;
      dsta_pkg::TX_PBEG: begin
        tx_st_d = tx_more_words ? dsta_pkg::TX_PAY : dsta_pkg::TX_PFIN;
      end
      dsta_pkg::TX_PAY:  if (last_word_trigger) tx_st_d = dsta_pkg::TX_PFIN;
      dsta_pkg::TX_PFIN: tx_st_d = dsta_pkg::TX_FFIN;
      dsta_pkg::TX_FFIN: tx_st_d = dsta_pkg::TX_IDLE;
      default:           tx_st_d = dsta_pkg::TX_IDLE;
    endcase
  end

  // header words taken once this edge has passed
  always_comb begin
    hdr_cnt_d = hdr_cnt_q;
    if (tx_st_q == dsta_pkg::TX_SOF) begin
      hdr_cnt_d = 4'h0;
    end else if (tx_src_rdy && tx_dst_rdy &&
                 tx_st_q == dsta_pkg::TX_HDR &&
                 hdr_cnt_q != dsta_pkg::HDR_WORDS) begin
      hdr_cnt_d = hdr_cnt_q + 4'h1;
    end
  end

  // transmit state, markers and data, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q              <= dsta_pkg::TX_IDLE;
      hdr_cnt_q            <= 4'h0;
      tx_data              <= 32'h0000_0000;
      tx_src_rdy           <= 1'b0;
      tx_sof               <= 1'b0;
      payload_start_marker <= 1'b0;
      payload_end_marker   <= 1'b0;
      tx_eof               <= 1'b0;
    end else begin
      tx_st_q   <= tx_st_d;
      hdr_cnt_q <= hdr_cnt_d;
      if (!tx_src_rdy || tx_dst_rdy) begin
        tx_data    <= tx_word;
        // stop offering once the eighth word is taken
        tx_src_rdy <= tx_word_valid &&
                      ((tx_st_d == dsta_pkg::TX_HDR &&
                        hdr_cnt_d != dsta_pkg::HDR_WORDS) ||
                       tx_st_d == dsta_pkg::TX_PBEG ||
                       tx_st_d == dsta_pkg::TX_PAY);
      end
      tx_sof               <= tx_st_d == dsta_pkg::TX_SOF;
      payload_start_marker <= tx_st_d == dsta_pkg::TX_PBEG;
      payload_end_marker   <= tx_st_d == dsta_pkg::TX_PFIN;
      tx_eof               <= tx_st_d == dsta_pkg::TX_FFIN;
    end
  end

  // receive aligner datapath
  always_comb begin
    shift_off = pay_addr_q[2:0];
    wa        = base_q + (AW-2)'(slot_q);
    active    = rx_st_q == dsta_pkg::RX_BURST ||
                rx_st_q == dsta_pkg::RX_FOOT;
    pad       = outl_q == '0 || wa < cur_q[AW-1:2];
    f         = cur_q[1:0];
    room      = 3'd4 - {1'b0, f};
    k         = (outl_q < LEN_W'(room)) ? outl_q[2:0] : room;
    pb        = (inl_q >= LEN_W'(4)) ? 3'd4 : inl_q[2:0];
    // header words are dropped until payload start
    push      = rx_dst_rdy && rx_src_rdy &&
                (rx_st_q != dsta_pkg::RX_HDR || rx_sop);
    // new word appended after held bytes
    win       = push ? (buf_q | ({rx_data, 32'h0} >> {nb_q[2:0], 3'b000}))
                     : buf_q;
    have      = nb_q + (push ? {1'b0, pb} : 4'h0);
    emit      = active && (pad || have >= {1'b0, k});
    cons      = (emit && !pad) ? k : 3'd0;
    // rotate first byte into lane f
    word_out  = win[63:32] >> {f, 3'b000};
    mask      = pad ? dsta_pkg::MASK_PAD : lane_mask(f, k);
    if (foot_q && slot_q < dsta_pkg::FOOT_KEEP) begin
      mask = dsta_pkg::MASK_PAD;
    end
    buf_d     = win << {cons, 3'b000};
    nb_d      = have - {1'b0, cons};
    cur_d     = cur_q + AW'(cons);
    outl_d    = outl_q - LEN_W'(cons);
    inl_d     = inl_q - (push ? LEN_W'(pb) : '0);
    last_slot = slot_q == (foot_q ? dsta_pkg::LINE_LAST
                                  : dsta_pkg::BURST_LAST);
  end

  // receive phase sequencer
  always_comb begin
    rx_st_d = rx_st_q;
    unique case (rx_st_q)
      dsta_pkg::RX_IDLE: if (rx_frame_start) rx_st_d = dsta_pkg::RX_HDR;
      dsta_pkg::RX_HDR:  if (push) rx_st_d = dsta_pkg::RX_WAIT;
      dsta_pkg::RX_WAIT: begin
        if (line8_write_request) begin
          rx_st_d = dsta_pkg::RX_FOOT;
        end else if (burst32_write_request) begin
          rx_st_d = dsta_pkg::RX_BURST;
        end
      end
      dsta_pkg::RX_BURST: if (emit && last_slot) rx_st_d = dsta_pkg::RX_WAIT;
      dsta_pkg::RX_FOOT:  if (emit && last_slot) rx_st_d = dsta_pkg::RX_IDLE;
      default:            rx_st_d = dsta_pkg::RX_IDLE;
    endcase
  end

  // receive counters, window and slot position
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q <= dsta_pkg::RX_IDLE;
      cur_q   <= '0;
      outl_q  <= '0;
      inl_q   <= '0;
      buf_q   <= 64'h0;
      nb_q    <= 4'h0;
      slot_q  <= 5'h00;
      base_q  <= '0;
      foot_q  <= 1'b0;
    end else begin
      rx_st_q <= rx_st_d;
      buf_q   <= buf_d;
      nb_q    <= nb_d;
      cur_q   <= cur_d;
      outl_q  <= outl_d;
      inl_q   <= inl_d;
      if (emit) begin
        slot_q <= last_slot ? 5'h00 : slot_q + 5'h01;
      end
      if (rx_st_q == dsta_pkg::RX_IDLE && rx_frame_start) begin
        // low three address bits are the shift offset
        cur_q  <= {pay_addr_q[AW-1:3], shift_off};
        outl_q <= pay_len_q;
        inl_q  <= pay_len_q;
        foot_q <= 1'b0;
        buf_q  <= 64'h0;
        nb_q   <= 4'h0;
      end else if (rx_st_q == dsta_pkg::RX_WAIT && line8_write_request) begin
        cur_q  <= foot_addr_q;
        base_q <= foot_addr_q[AW-1:2];
        outl_q <= LEN_W'(dsta_pkg::FOOT_BYTES);
        inl_q  <= LEN_W'(dsta_pkg::FOOT_BYTES);
        foot_q <= 1'b1;
        buf_q  <= 64'h0;
        nb_q   <= 4'h0;
        slot_q <= 5'h00;
      end else if (rx_st_q == dsta_pkg::RX_WAIT && burst32_write_request) begin
        base_q <= {cur_q[AW-1:7], 5'h00};
        slot_q <= 5'h00;
      end
    end
  end

  // word load sequencer
  always_comb begin
    sh_d = sh_q;
    unique case (sh_q)
      dsta_pkg::SH_IDLE: begin
        if (rx_st_q == dsta_pkg::RX_IDLE && rx_frame_start) begin
          sh_d = dsta_pkg::SH_EVEN;
        end
      end
      dsta_pkg::SH_EVEN: if (push) sh_d = dsta_pkg::SH_ODD;
      dsta_pkg::SH_ODD:  if (push) sh_d = dsta_pkg::SH_EVEN;
      default:           sh_d = dsta_pkg::SH_IDLE;
    endcase
    if (rx_st_q == dsta_pkg::RX_WAIT && line8_write_request) begin
      sh_d = dsta_pkg::SH_EVEN;
    end
    if (foot_q && rx_st_d == dsta_pkg::RX_IDLE) begin
      sh_d = dsta_pkg::SH_IDLE;
    end
  end

  assign load_even = push && sh_q == dsta_pkg::SH_EVEN;
  assign load_odd  = push && sh_q == dsta_pkg::SH_ODD;

  // load sequencer state and stream ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_q       <= dsta_pkg::SH_IDLE;
      rx_dst_rdy <= 1'b0;
    end else begin
      sh_q <= sh_d;
      // header drained, payload pulled while window has room
      rx_dst_rdy <= rx_st_d == dsta_pkg::RX_HDR ||
                    ((rx_st_d == dsta_pkg::RX_BURST ||
                      rx_st_d == dsta_pkg::RX_FOOT) &&
                     nb_d < 4'h4 && inl_d != '0 &&
                     !(rx_st_q == dsta_pkg::RX_WAIT && line8_write_request));
    end
  end

  // memory write port, parity of slot address picks the register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_word_even   <= 32'h0000_0000;
      write_word_odd    <= 32'h0000_0000;
      write_mask_even   <= dsta_pkg::MASK_PAD;
      write_mask_odd    <= dsta_pkg::MASK_PAD;
      write_accept_even <= 1'b0;
      write_accept_odd  <= 1'b0;
    end else begin
      write_accept_even <= emit && !wa[0];
      write_accept_odd  <= emit && wa[0];
      if (emit && !wa[0]) begin
        write_word_even <= word_out;
        write_mask_even <= mask;
      end
      // data for odd slots shares the same window
      if (emit && wa[0]) begin
        write_word_odd <= word_out;
        write_mask_odd <= mask;
      end
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_tx_tail;
    payload_end_marker ##1 tx_eof ##1 (tx_st_q == dsta_pkg::TX_IDLE);
  endsequence
  sequence s_tx_begin;
    payload_start_marker && tx_st_q == dsta_pkg::TX_PBEG ##1
      (tx_st_q == dsta_pkg::TX_PAY || tx_st_q == dsta_pkg::TX_PFIN);
  endsequence

  property p_tx_hdr;
    tx_st_q == dsta_pkg::TX_SOF && tx_dst_rdy |=>
      tx_st_q == dsta_pkg::TX_HDR && !tx_sof;
  endproperty
  a_tx_hdr: assert property (p_tx_hdr) else $error("no header");
  property p_tx_begin;
    tx_st_q == dsta_pkg::TX_HDR && read_desc_done |=> s_tx_begin;
  endproperty
  a_tx_begin: assert property (p_tx_begin) else $error("sop");
  property p_tx_tail;
    tx_st_q == dsta_pkg::TX_PAY && last_word_trigger |=> s_tx_tail;
  endproperty
  a_tx_tail: assert property (p_tx_tail) else $error("tail");
  property p_hdr_drop;
    rx_st_q == dsta_pkg::RX_HDR && rx_dst_rdy && rx_src_rdy && !rx_sop
      |=> nb_q == 4'h0 && rx_st_q == dsta_pkg::RX_HDR;
  endproperty
  a_hdr_drop: assert property (p_hdr_drop) else $error("hdr kept");
  property p_burst_end;
    rx_st_q == dsta_pkg::RX_BURST && emit && slot_q == 5'h1f
      |=> rx_st_q == dsta_pkg::RX_WAIT;
  endproperty
  a_burst_end: assert property (p_burst_end) else $error("burst");
  property p_burst_align;
    rx_st_q == dsta_pkg::RX_BURST |-> base_q[4:0] == 5'h00;
  endproperty
  a_burst_align: assert property (p_burst_align) else $error("align");
  property p_foot_keep;
    rx_st_q == dsta_pkg::RX_FOOT && emit && slot_q < 5'h03
      |=> (write_accept_even && write_mask_even == 4'hf) ||
          (write_accept_odd && write_mask_odd == 4'hf);
  endproperty
  a_foot_keep: assert property (p_foot_keep) else $error("footer");
  property p_accept_alt;
    (write_accept_even |=> !write_accept_even) and
    (write_accept_odd |=> !write_accept_odd);
  endproperty
  a_accept_alt: assert property (p_accept_alt) else $error("alternate");
  property p_accept_one;
    !(write_accept_even && write_accept_odd);
  endproperty
  a_accept_one: assert property (p_accept_one) else $error("both");
  property p_toggle;
    load_even |=> sh_q == dsta_pkg::SH_ODD ||
                  sh_q == dsta_pkg::SH_EVEN && $past(foot_q) != foot_q ||
                  sh_q == dsta_pkg::SH_IDLE;
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle");
  property p_idle_loads;
    sh_q == dsta_pkg::SH_IDLE |-> !load_even && !load_odd;
  endproperty
  a_idle_loads: assert property (p_idle_loads) else $error("load");
  property p_off_steady;
    (load_even || load_odd) && !foot_q |=> $stable(shift_off);
  endproperty
  a_off_steady: assert property (p_off_steady) else $error("offset");
endmodule // dsta_top

// File: tb/dsta_far_model.sv
// far side model: receive stream source and transmit stream sink
`timescale 1ns/10ps
module dsta_far_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // receive stream toward the block
  output logic      [31:0] rx_data,
  output logic             rx_src_rdy,
  output logic             rx_sop,
  input  wire logic        rx_dst_rdy,
  // transmit sink, stalled on bench command
  input  wire logic        tx_stall,
  output logic             tx_dst_rdy
);
  logic [32:0] src_q[$]; // pending words, sop flag on top
  logic [2:0]  gap_q;    // pacing count, adds slow gaps

  // queue one word for delivery
  task automatic push(input logic [31:0] w, input logic s);
    src_q.push_back({s, w});
  endtask

  // one word at a time, held until taken
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_src_rdy <= 1'b0;
      rx_sop <= 1'b0;
      rx_data <= 32'h0;
      gap_q <= 3'h0;
    end else begin
      gap_q <= gap_q + 3'h1;
      if (rx_src_rdy && rx_dst_rdy) begin
        // taken: idle data flips so stale values never match
        void'(src_q.pop_front());
        rx_src_rdy <= 1'b0;
        rx_sop <= 1'b0;
        rx_data <= ~rx_data;
      end else if (!rx_src_rdy && src_q.size() > 0 && gap_q != 3'h7) begin
        rx_src_rdy <= 1'b1;
        {rx_sop, rx_data} <= src_q[0];
      end
    end
  end

  // sink ready follows the stall command one cycle late
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_dst_rdy <= 1'b0;
    end else begin
      tx_dst_rdy <= !tx_stall;
    end
  end
endmodule // dsta_far_model

// File: tb/tb_top.sv
// self-checking bench for the stream dma aligner
`timescale 1ns/10ps
module tb_top;
  // clock, reset and apb
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, tx_word, tx_data, rx_data;
  // orders and streams
  logic        tx_frame_start, read_desc_done, tx_more_words;
  logic        last_word_trigger, rx_frame_start, tx_stall;
  logic        burst32_write_request, line8_write_request;
  logic        tx_word_valid, tx_src_rdy, tx_dst_rdy, tx_sof, tx_eof;
  logic        payload_start_marker, payload_end_marker;
  logic        rx_src_rdy, rx_sop, rx_dst_rdy;
  // memory port
  logic [31:0] write_word_even, write_word_odd;
  logic [3:0]  write_mask_even, write_mask_odd;
  logic        write_accept_even, write_accept_odd;
  // bookkeeping
  int          error_cnt, checks, tx_cnt;
  logic [36:0] wq[$]; // {odd side, mask, word}

  dsta_top u_dsta_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .tx_frame_start, .read_desc_done,
    .tx_more_words, .last_word_trigger, .rx_frame_start,
    .burst32_write_request, .line8_write_request, .tx_word, .tx_word_valid,
    .tx_data, .tx_src_rdy, .tx_dst_rdy, .tx_sof, .payload_start_marker,
    .payload_end_marker, .tx_eof, .rx_data, .rx_src_rdy, .rx_sop,
    .rx_dst_rdy, .write_word_even, .write_word_odd, .write_mask_even,
    .write_mask_odd, .write_accept_even, .write_accept_odd);
  dsta_far_model far (.pclk, .presetn, .rx_data, .rx_src_rdy, .rx_sop,
    .rx_dst_rdy, .tx_stall, .tx_dst_rdy);

  // 100 mhz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // record memory writes and transmit handshakes
  always @(posedge pclk) begin
    if (tx_src_rdy === 1'b1 && tx_dst_rdy === 1'b1) tx_cnt++;
    if (write_accept_even === 1'b1)
      wq.push_back({1'b0, write_mask_even, write_word_even});
    if (write_accept_odd === 1'b1)
      wq.push_back({1'b1, write_mask_odd, write_word_odd});
  end

  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    checks++;
    if (got !== ex) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic conclude;
    if (error_cnt == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk("apb_wait", 32'h1, 32'(n));
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // pick a watched marker by index
  function automatic logic sel(input int i);
    case (i)
      0: return payload_end_marker;
      1: return tx_eof;
      default: return tx_sof;
    endcase
  endfunction

  task automatic wait_for(input string nm, input int i, input logic v);
    int n;
    n = 0;
    while (sel(i) !== v && n < 4) begin
      @(posedge pclk);
      n++;
    end
    chk(nm, 32'(v), 32'(sel(i)));
  endtask

  // poll status until the receive phase is reached
  task automatic wait_rx(input logic [2:0] st);
    logic [31:0] rd;
    logic        e;
    int          n;
    n = 0;
    rd = 32'hffff_ffff;
    while (rd[5:3] !== st && n < 400) begin
      apb(1'b0, dsta_pkg::OFS_STATUS, 32'h0, rd, e);
      n++;
    end
    chk("rx_state", 32'(st), 32'(rd[5:3]));
  endtask

  // reset values, read-only status, unmapped place
  task automatic t_regs;
    logic [31:0] rd;
    logic        e;
    apb(1'b0, dsta_pkg::OFS_PAY_ADDR, 32'h0, rd, e);
    chk("pay_addr", dsta_pkg::RST_PAY_ADDR, rd);
    apb(1'b0, dsta_pkg::OFS_FOOT_ADDR, 32'h0, rd, e);
    chk("foot_addr", dsta_pkg::RST_FOOT_ADDR, rd);
    apb(1'b1, dsta_pkg::OFS_STATUS, 32'hffff_ffff, rd, e);
    apb(1'b0, dsta_pkg::OFS_STATUS, 32'h0, rd, e);
    chk("status", 32'h0, rd);
    apb(1'b1, 8'h40, 32'h1234_5678, rd, e);
    chk("unmapped_err", 32'h1, 32'(e));
    apb(1'b0, 8'h40, 32'h0, rd, e);
    chk("unmapped_rd", 32'h0, rd);
  endtask

  // one transmit frame, with or without a payload loop
  task automatic t_tx(input logic more);
    logic [31:0] st;
    logic        e;
    tx_stall <= 1'b1;
    tx_frame_start <= 1'b1;
    @(posedge pclk);
    tx_frame_start <= 1'b0;
    wait_for("tx_sof", 2, 1'b1);
    repeat (3) @(posedge pclk);
    chk("tx_sof_held", 32'h1, 32'(tx_sof));
    tx_stall <= 1'b0;
    wait_for("tx_sof_drop", 2, 1'b0);
    tx_cnt = 0;
    tx_word_valid <= 1'b1;
    repeat (12) @(posedge pclk);
    tx_word_valid <= 1'b0;
    chk("hdr_words", 32'h8, 32'(tx_cnt));
    chk("hdr_data", tx_word, tx_data);
    read_desc_done <= 1'b1;
    tx_more_words <= more;
    @(posedge pclk);
    read_desc_done <= 1'b0;
    @(posedge pclk);
    chk("sop_mark", 32'h1, 32'(payload_start_marker));
    @(posedge pclk);
    chk("sop_pulse", 32'h0, 32'(payload_start_marker));
    if (more) begin
      repeat (3) @(posedge pclk);
      chk("eop_early", 32'h0, 32'(payload_end_marker));
      last_word_trigger <= 1'b1;
      @(posedge pclk);
      last_word_trigger <= 1'b0;
    end
    wait_for("eop_mark", 0, 1'b1);
    @(posedge pclk);
    chk("eof_mark", 32'h1, 32'(tx_eof));
    apb(1'b0, dsta_pkg::OFS_STATUS, 32'h0, st, e);
    chk("tx_idle", 32'(dsta_pkg::TX_IDLE), 32'(st[2:0]));
  endtask

  function automatic logic [7:0] pb(input int i);
    return 8'(i * 5 + 1);
  endfunction

  // 147 bytes to offset 0x76, three bursts, then the footer
  task automatic t_rx;
    logic [31:0] rd, ew, keep;
    logic [3:0]  em;
    logic        e;
    int          a;
    apb(1'b1, dsta_pkg::OFS_PAY_ADDR, 32'h0000_1076, rd, e);
    apb(1'b1, dsta_pkg::OFS_PAY_LEN, 32'h0000_0093, rd, e);
    apb(1'b1, dsta_pkg::OFS_FOOT_ADDR, 32'h0000_2000, rd, e);
    far.push(32'h5a5a_0001, 1'b0);
    far.push(32'h5a5a_0002, 1'b0);
    for (int w = 0; w < 37; w++)
      far.push({pb(4*w), pb(4*w+1), pb(4*w+2), pb(4*w+3)}, w == 0);
    for (int f = 0; f < 8; f++)
      far.push(32'hc0c0_0000 + 32'(f), 1'b0);
    rx_frame_start <= 1'b1;
    @(posedge pclk);
    rx_frame_start <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      wait_rx(dsta_pkg::RX_WAIT);
      burst32_write_request <= (k < 3);
      line8_write_request <= (k == 3);
      @(posedge pclk);
      burst32_write_request <= 1'b0;
      line8_write_request <= 1'b0;
    end
    wait_rx(dsta_pkg::RX_IDLE);
    chk("slots", 32'd104, 32'(wq.size()));
    for (int s = 0; s < 104 && s < wq.size(); s++) begin
      ew = 32'h0;
      em = 4'hf;
      if (s >= 96) begin
        ew = 32'hc0c0_0000 + 32'(s - 96);
        em = (s < 99) ? 4'hf : 4'h0;
      end else begin
        for (int j = 0; j < 4; j++) begin
          a = s * 4 + j - 118;
          if (a >= 0 && a < 147) begin
            em[3-j] = 1'b0;
            ew[31-8*j -: 8] = pb(a);
          end
        end
      end
      for (int j = 0; j < 4; j++)
        keep[31-8*j -: 8] = {8{!em[3-j]}};
      chk("slot_side", 32'(s % 2), 32'(wq[s][36]));
      chk("slot_mask", 32'(em), 32'(wq[s][35:32]));
      chk("slot_word", ew & keep, wq[s][31:0] & keep);
    end
  endtask

  // watchdog
  initial begin
    repeat (30000) @(posedge pclk);
    error_cnt++;
    conclude();
  end

  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, tx_frame_start} = '0;
    {read_desc_done, tx_more_words, last_word_trigger} = '0;
    {rx_frame_start, burst32_write_request, line8_write_request} = '0;
    {tx_word_valid, presetn} = '0;
    tx_word = 32'h0a5a_0c3c;
    tx_stall = 1'b1;
    error_cnt = 0;
    checks = 0;
    tx_cnt = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_tx(1'b1);
    t_tx(1'b0);
    t_rx();
    conclude();
  end
endmodule // tb_top
